// ---- hw/gp_port.sv ----
// Summary of operation
// - Open-drain: no pull-ups; drive low only while latch holds 0.
// - Open-drain with latch 1 behaves as input-only, no drive.
// - Input-only: high impedance, no driver, no pull-up.
// - Data register read returns pin state; write loads output latch.
// - Data registers accept single-bit writes.
// - Port 0 and 1 data reset to all ones, in every page.
// - Port 2 and 3 data reset to 0x01, in every page.
// - Port 2 bit 0 input-only when fuse is 0; reads 0 otherwise.
// - Port 3 bit 0 is GPIO only with internal oscillator selected.
// - As oscillator input, port 3 bit 0 ignores writes, reads 0.
// - Mode bits a,b: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
// - Each pin's mode is independent of every other pin.
// - After reset ports 0 to 2 and port 3 bit 0 are input-only; port 3 bits 1 to 7 are quasi.
// - Per-pin bit selects TTL or Schmitt input buffer.
// - Port 0 offers eight GPIO bits, one per data bit.
// - Quasi: very weak pull-up on latch 1; strong for two clocks on rise.
// - Push-pull: strong high while latch 1, low as quasi while 0.
// - Read-modify-write reads the output latch, not the pin.
//
// Our own choice: the strobed register port.
module gp_port
    import gp_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire gp_bus_req_t                 i_bus,
    output logic        [7:0]                o_rdata,
    input  wire logic                        i_fuse_rpd,
    input  wire logic                        i_int_osc_sel,
    input  wire logic   [GP_PORTS-1:0][7:0]  i_pin,
    output gp_pin_drv_t [GP_PORTS-1:0][7:0]  o_drv
);

    logic [GP_PORTS-1:0][7:0] latch;
    logic [GP_PORTS-1:0][7:0] next_latch;
    logic [2:0][7:0]          msa;
    logic [2:0][7:0]          next_msa;
    logic [2:0][7:0]          msb;
    logic [2:0][7:0]          next_msb;
    logic [2:0][7:0]          its;
    logic [2:0][7:0]          next_its;
    logic [7:0]               next_rdata;
    logic [GP_PORTS-1:0][7:0] pin_s1;
    logic [GP_PORTS-1:0][7:0] pin_s2;
    logic [GP_PORTS-1:0][7:0] pin_rd;

    // Pin synchroniser
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= i_pin;
            pin_s2 <= pin_s1;
        end
    end

    // Pin view with special pins gated
    always_comb begin
        pin_rd = pin_s2;
        if (i_fuse_rpd) begin
            pin_rd[2][0] = 1'b0;
        end
        if (!i_int_osc_sel) begin
            pin_rd[3][0] = 1'b0;
        end
    end

    function automatic logic [1:0] data_port(input logic [7:0] a);
        unique case (a)
            GP_PORT0_DATA: data_port = 2'h0;
            GP_PORT1_DATA: data_port = 2'h1;
            GP_PORT2_DATA: data_port = 2'h2;
            default:       data_port = 2'h3;
        endcase
    endfunction

    function automatic logic is_data(input logic [7:0] a);
        is_data = (a == GP_PORT0_DATA) || (a == GP_PORT1_DATA) ||
                  (a == GP_PORT2_DATA) || (a == GP_PORT3_DATA);
    endfunction

    // Register writes and read data
    always_comb begin
        logic [1:0] p;
        logic [7:0] lat3;
        logic [7:0] val;
        p          = data_port(i_bus.addr);
        lat3       = latch[3];
        val        = 8'h00;
        next_latch = latch;
        next_msa   = msa;
        next_msb   = msb;
        next_its   = its;
        next_rdata = 8'h00;
        if (i_bus.wr) begin
            if (is_data(i_bus.addr)) begin
                if (i_bus.bit_op) begin
                    next_latch[p][i_bus.bit_sel] = i_bus.wdata[0];
                end else begin
                    next_latch[p] = i_bus.wdata;
                end
            end else begin
                unique case (i_bus.addr)
                    GP_PORT0_MSA: next_msa[0] = i_bus.wdata;
                    GP_PORT0_MSB: next_msb[0] = i_bus.wdata;
                    GP_PORT1_MSA: next_msa[1] = i_bus.wdata;
                    GP_PORT1_MSB: next_msb[1] = i_bus.wdata;
                    GP_PORT3_MSA: next_msa[2] = i_bus.wdata;
                    GP_PORT3_MSB: next_msb[2] = i_bus.wdata;
                    default: begin
                        if (i_bus.page == GP_ITS_PAGE) begin
                            if (i_bus.addr == GP_PORT0_ITS) begin
                                next_its[0] = i_bus.wdata;
                            end
                            if (i_bus.addr == GP_PORT1_ITS) begin
                                next_its[1] = i_bus.wdata;
                            end
                            if (i_bus.addr == GP_PORT3_ITS) begin
                                next_its[2] = i_bus.wdata;
                            end
                        end
                    end
                endcase
            end
            if (!i_int_osc_sel) begin
                next_latch[3][0] = lat3[0];
            end
        end
        if (i_bus.rd) begin
            if (is_data(i_bus.addr)) begin
                if (i_bus.rmw) begin
                    val = latch[p];
                end else begin
                    val = pin_rd[p];
                end
            end else begin
                unique case (i_bus.addr)
                    GP_PORT0_MSA: val = msa[0];
                    GP_PORT0_MSB: val = msb[0];
                    GP_PORT1_MSA: val = msa[1];
                    GP_PORT1_MSB: val = msb[1];
                    GP_PORT3_MSA: val = msa[2];
                    GP_PORT3_MSB: val = msb[2];
                    default: begin
                        if (i_bus.page == GP_ITS_PAGE) begin
                            if (i_bus.addr == GP_PORT0_ITS) begin
                                val = its[0];
                            end
                            if (i_bus.addr == GP_PORT1_ITS) begin
                                val = its[1];
                            end
                            if (i_bus.addr == GP_PORT3_ITS) begin
                                val = its[2];
                            end
                        end
                    end
                endcase
            end
            next_rdata = val;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            latch[0] <= GP_RST_DATA01;
            latch[1] <= GP_RST_DATA01;
            latch[2] <= GP_RST_DATA23;
            latch[3] <= GP_RST_DATA23;
            msa[0]   <= GP_RST_MSA01;
            msa[1]   <= GP_RST_MSA01;
            msa[2]   <= GP_RST_MSA3;
            msb      <= {3{GP_RST_MSB}};
            its      <= {3{GP_RST_ITS}};
            o_rdata  <= 8'h00;
        end else begin
            latch    <= next_latch;
            msa      <= next_msa;
            msb      <= next_msb;
            its      <= next_its;
            o_rdata  <= next_rdata;
        end
    end

    // Per-pin driver; port 2 has no mode registers and stays input-only
    for (genvar gp = 0; gp < GP_PORTS; gp++) begin : g_port
        localparam int IX = (gp == 3) ? 2 : ((gp == 2) ? 0 : gp);
        for (genvar gb = 0; gb < GP_PINS; gb++) begin : g_pin
            logic [1:0] cnt;
            logic [1:0] next_cnt;
            logic [1:0] mode;
            logic       gated;
            logic       lat;

            assign lat   = latch[gp][gb];
            assign gated = (gp == 2) || ((gp == 3) && (gb == 0) && !i_int_osc_sel);

            always_comb begin
                if (gp == 2) begin
                    mode = GP_MODE_INPUT;
                end else begin
                    mode = {msa[IX][gb], msb[IX][gb]};
                end
            end

            // Strong pull-up window after a 0 to 1 latch change
            always_comb begin
                if (!lat && next_latch[gp][gb]) begin
                    next_cnt = GP_STRONG_CYC;
                end else if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else begin
                    next_cnt = 2'h0;
                end
            end

            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    cnt <= 2'h0;
                end else begin
                    cnt <= next_cnt;
                end
            end

            always_comb begin
                o_drv[gp][gb].out     = 1'b0;
                o_drv[gp][gb].oe      = 1'b0;
                o_drv[gp][gb].pu      = 1'b0;
                o_drv[gp][gb].schmitt = (gp == 2) ? 1'b0 : its[IX][gb];
                if (!gated) begin
                    unique case (mode)
                        GP_MODE_QUASI: begin
                            o_drv[gp][gb].pu  = lat;
                            o_drv[gp][gb].oe  = !lat || (cnt != 2'h0);
                            o_drv[gp][gb].out = lat;
                        end
                        GP_MODE_PUSH: begin
                            o_drv[gp][gb].oe  = 1'b1;
                            o_drv[gp][gb].out = lat;
                        end
                        GP_MODE_INPUT: begin
                            o_drv[gp][gb].oe  = 1'b0;
                        end
                        GP_MODE_OPEN: begin
                            o_drv[gp][gb].oe  = !lat;
                        end
                    endcase
                end
            end
        end
    end

endmodule

// ---- hw/gp_pkg.sv ----
package gp_pkg;

    localparam int GP_PINS  = 8;
    localparam int GP_PORTS = 4;

    // Data registers, present in every page
    localparam logic [7:0] GP_PORT0_DATA = 8'h80;
    localparam logic [7:0] GP_PORT1_DATA = 8'h90;
    localparam logic [7:0] GP_PORT2_DATA = 8'hA0;
    localparam logic [7:0] GP_PORT3_DATA = 8'hB0;

    // Mode select registers
    localparam logic [7:0] GP_PORT0_MSA  = 8'hB1;
    localparam logic [7:0] GP_PORT0_MSB  = 8'hB2;
    localparam logic [7:0] GP_PORT1_MSA  = 8'hB3;
    localparam logic [7:0] GP_PORT1_MSB  = 8'hB4;
    localparam logic [7:0] GP_PORT3_MSA  = 8'hC2;
    localparam logic [7:0] GP_PORT3_MSB  = 8'hC3;

    // Input type select registers, page 1 only
    localparam logic [7:0] GP_PORT0_ITS  = 8'hD1;
    localparam logic [7:0] GP_PORT1_ITS  = 8'hD2;
    localparam logic [7:0] GP_PORT3_ITS  = 8'hD3;
    localparam logic       GP_ITS_PAGE   = 1'b1;

    localparam logic [7:0] GP_RST_DATA01 = 8'hFF;
    localparam logic [7:0] GP_RST_DATA23 = 8'h01;
    localparam logic [7:0] GP_RST_MSA01  = 8'hFF;
    localparam logic [7:0] GP_RST_MSA3   = 8'h01;
    localparam logic [7:0] GP_RST_MSB    = 8'h00;
    localparam logic [7:0] GP_RST_ITS    = 8'h00;

    // Mode codes {select_a, select_b}
    localparam logic [1:0] GP_MODE_QUASI = 2'h0;
    localparam logic [1:0] GP_MODE_PUSH  = 2'h1;
    localparam logic [1:0] GP_MODE_INPUT = 2'h2;
    localparam logic [1:0] GP_MODE_OPEN  = 2'h3;

    // Strong pull-up length in CPU clocks
    localparam logic [1:0] GP_STRONG_CYC = 2'h2;

    typedef struct packed {
        logic       page;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [2:0] bit_sel;
        logic       rmw;
    } gp_bus_req_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
        logic schmitt;
    } gp_pin_drv_t;

endpackage

// ---- verification/gp_checker.sv ----
module gp_checker
    import gp_pkg::*;
(
    input  wire logic                            i_clk,
    input  wire logic                            i_rst,
    input  wire gp_bus_req_t                     i_bus,
    input  wire logic        [7:0]               o_rdata,
    input  wire logic                            i_fuse_rpd,
    input  wire logic                            i_int_osc_sel,
    input  wire logic        [GP_PORTS-1:0][7:0] i_pin,
    input  wire gp_pin_drv_t [GP_PORTS-1:0][7:0] o_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rd_idle; !$past(i_bus.rd) |-> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rst; $past(i_rst) |-> !o_drv[0][0].oe && !o_drv[0][0].pu && !o_drv[1][7].oe;
    endproperty
    a_rst: assert property (p_rst) else $error("pin not input-only after reset");
    property p_p2_idle; !o_drv[2][0].oe && !o_drv[2][7].oe; endproperty
    a_p2_idle: assert property (p_p2_idle) else $error("port two driven");
    property p_osc; !i_int_osc_sel && !$past(i_int_osc_sel) |-> !o_drv[3][0].oe; endproperty
    a_osc: assert property (p_osc) else $error("oscillator pin driven");
    property p_its; i_bus.wr && i_bus.page && i_bus.addr == GP_PORT0_ITS && !i_bus.bit_op
        |=> o_drv[0][3].schmitt == $past(i_bus.wdata[3]); endproperty
    a_its: assert property (p_its) else $error("input type not applied");
    property p_pin_rd; i_bus.rd && i_bus.addr == GP_PORT1_DATA && !i_bus.rmw
        && $stable(i_pin[1]) && i_pin[1] == $past(i_pin[1], 2)
        |=> o_rdata == $past(i_pin[1], 2); endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("data read not pin state");
    property p_fuse; i_bus.rd && i_bus.addr == GP_PORT2_DATA && !i_bus.rmw && i_fuse_rpd
        |=> o_rdata[0] == 1'b0; endproperty
    a_fuse: assert property (p_fuse) else $error("fused bit not zero");
    property p_osc_rd; i_bus.rd && i_bus.addr == GP_PORT3_DATA && !i_bus.rmw
        && !i_int_osc_sel |=> o_rdata[0] == 1'b0; endproperty
    a_osc_rd: assert property (p_osc_rd) else $error("oscillator bit not zero");
    c_its: cover property (i_bus.wr && i_bus.page && i_bus.addr == GP_PORT0_ITS);
    c_strong: cover property ($rose(o_drv[0][0].oe && o_drv[0][0].out));
    c_fuse: cover property (i_bus.rd && i_bus.addr == GP_PORT2_DATA && i_fuse_rpd);
endmodule

bind gp_port gp_checker chk (.i_clk, .i_rst, .i_bus, .o_rdata, .i_fuse_rpd, .i_int_osc_sel,
    .i_pin, .o_drv);

// ---- verification/gp_pins.sv ----
module gp_pins
    import gp_pkg::*;
(
    input  wire gp_pin_drv_t [GP_PORTS-1:0][7:0] i_drv,
    input  wire logic        [GP_PORTS-1:0][7:0] i_ext,
    output logic             [GP_PORTS-1:0][7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Resistor level unless the port drives strongly
    always_comb begin
        for (int p = 0; p < GP_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                o_pin[p][b] = i_drv[p][b].oe ? i_drv[p][b].out : i_ext[p][b];
            end
        end
    end
endmodule

// ---- verification/tb.sv ----
module tb
    import gp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                            i_clk = 1'b0;
    logic                            i_rst = 1'b1;
    gp_bus_req_t                     i_bus = '0;
    logic        [7:0]               o_rdata;
    logic                            i_fuse_rpd = 1'b1;
    logic                            i_int_osc_sel = 1'b1;
    logic        [GP_PORTS-1:0][7:0] i_pin;
    logic        [GP_PORTS-1:0][7:0] ext = '1;
    gp_pin_drv_t [GP_PORTS-1:0][7:0] o_drv;
    logic        [7:0]               r;
    int                              n_fail = 0;
    int                              checks = 0;
    int                              cyc = 0;
    gp_port uut (.i_clk, .i_rst, .i_bus, .o_rdata, .i_fuse_rpd, .i_int_osc_sel, .i_pin, .o_drv);
    gp_pins pins (.i_drv(o_drv), .i_ext(ext), .o_pin(i_pin));
    always #4 i_clk = ~i_clk;
    task automatic test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task automatic bus(input logic w, pg, bo, rm, input logic [7:0] a, d, input logic [2:0] bs);
        @(posedge i_clk);
        i_bus <= '{pg, a, d, w, !w, bo, bs, rm};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        r = o_rdata;
    endtask
    // Port 0 pin b drive as {oe, strong high, weak pull-up}
    function automatic logic [7:0] dv(int b);
        return {5'h00, o_drv[0][b].oe, o_drv[0][b].oe & o_drv[0][b].out, o_drv[0][b].pu};
    endfunction
    task automatic t_reset();
        logic [7:0] a [11] = '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hC2,
            8'hC3, 8'h00};
        logic [7:0] e [11] = '{8'hFF, 8'hFF, 8'h01, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h01,
            8'h00, 8'h00};
        chk("drv_rst", 8'h00, dv(5));
        for (int i = 0; i < 11; i++) begin
            bus(0, i[0], 0, 1, a[i], 8'h00, 3'h0);
            chk("reset", e[i], r);
        end
    endtask
    task automatic t_open();
        bus(1, 0, 0, 0, 8'hB2, 8'h01, 3'h0);
        chk("od_hi", 8'h00, dv(0));
        bus(1, 0, 1, 0, 8'h80, 8'h00, 3'h0);
        chk("od_lo", 8'h04, dv(0));
        chk("pin1", 8'h00, dv(1));
        bus(0, 0, 0, 1, 8'h80, 8'h00, 3'h0);
        chk("p0_lat", 8'hFE, r);
    endtask
    task automatic t_quasi();
        bus(1, 0, 0, 0, 8'hB2, 8'h00, 3'h0);
        bus(1, 1, 0, 0, 8'hB1, 8'hFE, 3'h0);
        chk("q_lo", 8'h04, dv(0));
        bus(1, 0, 1, 0, 8'h80, 8'h01, 3'h0);
        chk("strong1", 8'h07, dv(0));
        @(posedge i_clk);
        #1 chk("strong2", 8'h07, dv(0));
        @(posedge i_clk);
        #1 chk("weak", 8'h01, dv(0));
        bus(1, 0, 0, 0, 8'hB2, 8'h01, 3'h0);
        repeat (3) @(posedge i_clk);
        #1 chk("push", 8'h06, dv(0) & 8'h06);
    endtask
    task automatic t_read();
        @(posedge i_clk);
        ext[1] <= 8'h3C;
        repeat (4) @(posedge i_clk);
        bus(0, 0, 0, 0, 8'h90, 8'h00, 3'h0);
        chk("p1_pin", 8'h3C, r);
        bus(0, 1, 0, 1, 8'h90, 8'h00, 3'h0);
        chk("p1_lat", 8'hFF, r);
        bus(0, 0, 0, 0, 8'hA0, 8'h00, 3'h0);
        chk("p2_fuse", 8'hFE, r);
        @(posedge i_clk);
        i_fuse_rpd <= 1'b0;
        bus(0, 0, 0, 0, 8'hA0, 8'h00, 3'h0);
        chk("p2_in", 8'hFF, r);
        @(posedge i_clk);
        i_int_osc_sel <= 1'b0;
        bus(1, 0, 0, 0, 8'hC2, 8'h00, 3'h0);
        bus(1, 0, 0, 0, 8'hC3, 8'h01, 3'h0);
        bus(1, 0, 0, 0, 8'hB0, 8'h00, 3'h0);
        chk("osc_oe", 8'h00, {7'h00, o_drv[3][0].oe});
        bus(0, 0, 0, 1, 8'hB0, 8'h00, 3'h0);
        chk("osc_lat", 8'h01, r);
        bus(0, 0, 0, 0, 8'hB0, 8'h00, 3'h0);
        chk("osc_pin", 8'h00, r);
        @(posedge i_clk);
        i_int_osc_sel <= 1'b1;
        bus(1, 0, 1, 0, 8'hB0, 8'h00, 3'h0);
        bus(0, 0, 0, 1, 8'hB0, 8'h00, 3'h0);
        chk("gpio_lat", 8'h00, r);
        chk("gpio_oe", 8'h02, {6'h00, o_drv[3][0].oe, o_drv[3][0].out});
    endtask
    task automatic t_its();
        logic [7:0] s;
        bus(1, 0, 0, 0, GP_PORT0_ITS, 8'h5A, 3'h0);
        bus(0, 1, 0, 0, GP_PORT0_ITS, 8'h00, 3'h0);
        chk("its_pg0", GP_RST_ITS, r);
        bus(1, 1, 0, 0, GP_PORT0_ITS, 8'h5A, 3'h0);
        for (int b = 0; b < 8; b++) begin
            s[b] = o_drv[0][b].schmitt;
        end
        chk("schmitt", 8'h5A, s);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_open();
        t_quasi();
        t_read();
        t_its();
        test_done();
    end
endmodule
